// ---- logic/itf_channel.sv ----
// Serial audio transmit channel with word FIFO and clock generator.
//
// What this block does
// - Channel 0 forwards word-select rising edges to ADC when trigger and dividers run.
// - Transmit FIFO holds 32 words of 32 bits, filled through the window.
// - Only 4-byte window writes enter the FIFO; smaller ones are ignored.
// - Window sits at 1800H for channel 0, 1810H for channel 1.
// - Empty flag reads 1 once the last word has moved to the shifter.
// - In mono, word-select polarity swaps first and second sample order.
// - FIFO works as two halves; an interrupt marks each half emptied.
// - Each FIFO to shifter transfer moves exactly one word.
// - Interrupt after the 16th and 32nd word of a fill leave.
// - With transmit run set, shifting continues while FIFO holds data.
// - Clearing transmit run flushes FIFO and shifter; dividers clear unless running.
// - Restarting after a stop sends none of the discarded data.
// - Idle: word select low, bit clock low for rising, high for falling.
// - Divider run starts both dividers; clearing it stops and clears them.
// - Bit-clock divider divides source by 3..256; zero means 256.
// - Word-select divider divides bit clock by 16..64; zero means 64.
// - I2S, left- and right-justified alignment in stereo and mono.
`timescale 1ns/1ps
`default_nettype none

module itf_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic in_full,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("itf_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic full_r, full_nxt;
  logic push, pop;

  assign in_ready = ~full_r;
  assign in_full = full_r;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];

  always_comb begin
    push = in_valid & ~full_r;
    pop = out_ready & (cnt_r != '0);
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (flush) begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end else begin
      if (push) begin
        wp_nxt = AW'(wp_r + 1'b1);
      end
      if (pop) begin
        rp_nxt = AW'(rp_r + 1'b1);
      end
      cnt_nxt = (AW+1)'(cnt_r + push - pop);
    end
    full_nxt = (cnt_nxt == (AW+1)'(DEPTH));
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      full_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      full_r <= full_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push && !flush) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule

module itf_channel
  import itf_pkg::*;
#(
  parameter int CH = 0,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire itf_req_s cpu_req,
  output logic [31:0] cpu_rdata,
  output logic win_full,
  input wire logic pll_tick,
  output logic bit_clock_out,
  output logic frame_select_out,
  output logic serial_data_out,
  output logic adc_start,
  output logic fifo_space_irq
);
  if (CH < 0 || CH > 1 || DEPTH != 32) begin : g_bad_cfg
    $error("itf_channel: CH must be 0 or 1 and DEPTH must be 32");
  end

  localparam logic [15:0] WIN = (CH == 0) ? ITF_WIN_CH0 : ITF_WIN_CH1;
  localparam logic [15:0] CTL = WIN + ITF_CTL_OFS;
  localparam logic [15:0] DIV = WIN + ITF_DIV_OFS;

  function automatic logic [8:0] eff_div(input logic [7:0] s,
                                         input logic [8:0] full);
    return (s == 8'h00) ? full : {1'b0, s};
  endfunction

  function automatic logic [15:0] reg_wr(input logic [15:0] old,
                                         input logic [15:0] mask,
                                         input itf_req_s q,
                                         input logic [15:0] base);
    logic [15:0] v;
    v = old;
    if (q.wr && q.addr == base && q.size != ITF_SZ_1) begin
      v = (old & ~mask) | (q.wdata[15:0] & mask);
    end else if (q.wr && q.addr == base && q.size == ITF_SZ_1) begin
      v[7:0] = (old[7:0] & ~mask[7:0]) | (q.wdata[7:0] & mask[7:0]);
    end else if (q.wr && q.addr == 16'(base + 16'h0001)
                 && q.size == ITF_SZ_1) begin
      v[15:8] = (old[15:8] & ~mask[15:8]) | (q.wdata[7:0] & mask[15:8]);
    end
    return v;
  endfunction

  logic [15:0] ctl_r, ctl_nxt, div_r, div_nxt, ctl_view;
  logic [31:0] rdata_r, rdata_nxt, cur_r, cur_nxt, w, f_data;
  logic [15:0] smp_r, smp_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [5:0] b_r, b_nxt, nb;
  logic [3:0] popc_r, popc_nxt;
  logic [2:0] rem_r, rem_nxt, r, k, spw;
  logic ck_r, ck_nxt, started_r, started_nxt, lj_r, lj_nxt, sd_r, sd_nxt;
  logic bck_r, bck_nxt, ws_r, ws_nxt, adc_r, adc_nxt, irq_r, irq_nxt;
  logic tx, drun, tick, shift, nws, slot, st, l16, inwin, bitv, ckg;
  logic push, pop, f_valid, f_full, flush;
  logic [8:0] n, nlo, m, mlo, nhp, hn, len, s, idx;

  assign cpu_rdata = rdata_r;
  assign bit_clock_out = bck_r;
  assign frame_select_out = ws_r;
  assign serial_data_out = sd_r;
  assign adc_start = adc_r;
  assign fifo_space_irq = irq_r;

  itf_fifo #(.W(32), .DEPTH(DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .flush(flush),
    .in_valid(push),
    .in_data(cpu_req.wdata),
    .in_ready(),
    .in_full(f_full),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(pop)
  );
  assign win_full = f_full;

  always_comb begin
    tx = ctl_r[ITF_B_TX_RUN];
    drun = ctl_r[ITF_B_DIV_RUN];
    l16 = ctl_r[ITF_B_LEN16];
    spw = l16 ? 3'h2 : 3'h4;
    len = l16 ? 9'h010 : 9'h008;
    push = cpu_req.wr && cpu_req.addr == WIN && cpu_req.size == ITF_SZ_4;
    ctl_nxt = reg_wr(ctl_r, ITF_CTL_WMASK, cpu_req, CTL);
    div_nxt = reg_wr(div_r, ITF_DIV_WMASK, cpu_req, DIV);
    flush = tx && !ctl_nxt[ITF_B_TX_RUN];
    ctl_view = ctl_r;
    ctl_view[ITF_B_EMPTY] = ~f_valid;
    rdata_nxt = rdata_r;
    if (cpu_req.rd) begin
      rdata_nxt = 32'h0000_0000;
      if (cpu_req.addr == CTL) begin
        rdata_nxt = {16'h0000, ctl_view};
      end else if (cpu_req.addr == 16'(CTL + 16'h0001)) begin
        rdata_nxt = {24'h000000, ctl_view[15:8]};
      end else if (cpu_req.addr == DIV) begin
        rdata_nxt = {16'h0000, div_r};
      end else if (cpu_req.addr == 16'(DIV + 16'h0001)) begin
        rdata_nxt = {24'h000000, div_r[15:8]};
      end
    end

    n = eff_div(div_r[ITF_B_CKDIV +: 8], ITF_CK_FULL);
    m = eff_div({2'h0, div_r[ITF_B_WSDIV +: 6]}, ITF_WS_FULL);
    nlo = n >> 1;
    mlo = m >> 1;
    tick = ctl_r[ITF_B_SRC] ? pll_tick : 1'b1;
    cnt_nxt = cnt_r;
    ck_nxt = ck_r;
    b_nxt = b_r;
    shift = 1'b0;
    // dividers run only with divider run set
    if (!drun) begin
      cnt_nxt = 8'h00;
      ck_nxt = 1'b0;
      b_nxt = 6'h00;
    end else if (tick) begin
      if ({1'b0, cnt_r} == 9'(n - 9'h001)) begin
        cnt_nxt = 8'h00;
        ck_nxt = 1'b0;
      end else begin
        cnt_nxt = 8'(cnt_r + 8'h01);
      end
      if ({1'b0, cnt_r} == 9'(nlo - 9'h001)) begin
        ck_nxt = 1'b1;
        shift = 1'b1;
      end
    end
    nb = b_r;
    if (shift) begin
      nb = ({3'h0, b_r} == 9'(m - 9'h001)) ? 6'h00 : 6'(b_r + 6'h01);
      b_nxt = nb;
    end
    nws = ({3'h0, nb} >= mlo);
    nhp = nws ? 9'({3'h0, nb} - mlo) : {3'h0, nb};
    hn = nws ? 9'(m - mlo) : mlo;
    slot = shift && (nb == 6'h00 || {3'h0, nb} == mlo);

    adc_nxt = (CH == 0) && ctl_r[ITF_B_ADC] && drun && shift
              && {3'h0, nb} == mlo;

    cur_nxt = cur_r;
    rem_nxt = rem_r;
    started_nxt = started_r;
    smp_nxt = smp_r;
    lj_nxt = lj_r;
    sd_nxt = sd_r;
    popc_nxt = popc_r;
    irq_nxt = 1'b0;
    pop = 1'b0;
    w = cur_r;
    r = rem_r;
    k = 3'h0;
    st = started_r;
    s = 9'h000;
    idx = 9'h000;
    inwin = 1'b0;
    bitv = 1'b0;
    if (!tx) begin
      cur_nxt = 32'h0000_0000;
      rem_nxt = 3'h0;
      started_nxt = 1'b0;
      smp_nxt = 16'h0000;
      lj_nxt = 1'b0;
      sd_nxt = 1'b0;
      popc_nxt = 4'h0;
    end else if (shift) begin
      if (slot) begin
        st = started_r | (nws == ctl_r[ITF_B_POL]);
        started_nxt = st;
        smp_nxt = 16'h0000;
        if (st && (!ctl_r[ITF_B_MONO] || !nws)) begin
          if (rem_r == 3'h0 && f_valid) begin
            pop = 1'b1;
            w = f_data;
            r = spw;
          end
          if (r != 3'h0) begin
            k = 3'(spw - r);
            if (ctl_r[ITF_B_MONO] && ctl_r[ITF_B_POL]) begin
              k = k ^ 3'h1;
            end
            smp_nxt = l16 ? w[k[0]*16 +: 16] : {8'h00, w[k[1:0]*8 +: 8]};
            cur_nxt = w;
            rem_nxt = 3'(r - 3'h1);
          end
        end
      end
      if (ctl_r[ITF_B_FMT +: 2] == ITF_FMT_RJ && hn >= len) begin
        s = 9'(hn - len);
      end
      idx = 9'(nhp - s);
      inwin = (nhp >= s) && (nhp < 9'(s + len));
      if (inwin) begin
        bitv = ctl_r[ITF_B_LSB] ? smp_nxt[idx[3:0]]
                                : smp_nxt[4'(len - 9'h001 - idx)];
      end
      lj_nxt = bitv;
      sd_nxt = (ctl_r[ITF_B_FMT +: 2] == ITF_FMT_I2S) ? lj_r : bitv;
      // pulse after each 16-word half leaves
      if (pop) begin
        popc_nxt = 4'(popc_r + 4'h1);
        irq_nxt = (popc_r == ITF_HALF_LAST);
      end
    end

    ckg = ck_nxt & ~(ctl_r[ITF_B_IDLE_OFF] & ~tx);
    bck_nxt = ctl_r[ITF_B_EDGE] ? ckg : ~ckg;
    ws_nxt = ({3'h0, b_nxt} >= mlo);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= ITF_CTL_RST;
      div_r <= ITF_DIV_RST;
      rdata_r <= 32'h0000_0000;
      cnt_r <= 8'h00;
      ck_r <= 1'b0;
      b_r <= 6'h00;
      cur_r <= 32'h0000_0000;
      rem_r <= 3'h0;
      started_r <= 1'b0;
      smp_r <= 16'h0000;
      lj_r <= 1'b0;
      sd_r <= 1'b0;
      popc_r <= 4'h0;
      irq_r <= 1'b0;
      adc_r <= 1'b0;
      bck_r <= 1'b1;
      ws_r <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      div_r <= div_nxt;
      rdata_r <= rdata_nxt;
      cnt_r <= cnt_nxt;
      ck_r <= ck_nxt;
      b_r <= b_nxt;
      cur_r <= cur_nxt;
      rem_r <= rem_nxt;
      started_r <= started_nxt;
      smp_r <= smp_nxt;
      lj_r <= lj_nxt;
      sd_r <= sd_nxt;
      popc_r <= popc_nxt;
      irq_r <= irq_nxt;
      adc_r <= adc_nxt;
      bck_r <= bck_nxt;
      ws_r <= ws_nxt;
    end
  end
endmodule

`default_nettype wire

// ---- logic/itf_pkg.sv ----
// Constants and types shared by the serial audio transmit channel.
package itf_pkg;
  // Register byte addresses
  localparam logic [15:0] ITF_WIN_CH0 = 16'h1800;
  localparam logic [15:0] ITF_WIN_CH1 = 16'h1810;
  localparam logic [15:0] ITF_CTL_OFS = 16'h0008;
  localparam logic [15:0] ITF_DIV_OFS = 16'h000a;
  // Channel control fields
  localparam int ITF_B_ADC = 0;
  localparam int ITF_B_FMT = 1;
  localparam int ITF_B_LEN16 = 3;
  localparam int ITF_B_LSB = 4;
  localparam int ITF_B_DIV_RUN = 6;
  localparam int ITF_B_TX_RUN = 7;
  localparam int ITF_B_IDLE_OFF = 8;
  localparam int ITF_B_EDGE = 9;
  localparam int ITF_B_POL = 10;
  localparam int ITF_B_EMPTY = 11;
  localparam int ITF_B_MONO = 12;
  localparam int ITF_B_SRC = 15;
  // Divider setting fields
  localparam int ITF_B_CKDIV = 0;
  localparam int ITF_B_WSDIV = 8;
  // Reset values and writable bits
  localparam logic [15:0] ITF_CTL_RST = 16'h0000;
  localparam logic [15:0] ITF_DIV_RST = 16'h0000;
  localparam logic [15:0] ITF_CTL_WMASK = 16'h97df;
  localparam logic [15:0] ITF_DIV_WMASK = 16'h3fff;
  // Access sizes
  localparam logic [1:0] ITF_SZ_1 = 2'h0;
  localparam logic [1:0] ITF_SZ_2 = 2'h1;
  localparam logic [1:0] ITF_SZ_4 = 2'h2;
  // Alignment codes
  localparam logic [1:0] ITF_FMT_I2S = 2'h0;
  localparam logic [1:0] ITF_FMT_RJ = 2'h2;
  // Divider full-scale values meant by a zero setting
  localparam logic [8:0] ITF_CK_FULL = 9'h100;
  localparam logic [8:0] ITF_WS_FULL = 9'h040;
  // Pop count of the last word in a FIFO half
  localparam logic [3:0] ITF_HALF_LAST = 4'hf;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] size;
    logic [15:0] addr;
    logic [31:0] wdata;
  } itf_req_s;
endpackage

// ---- verif/itf_channel_tb_top.sv ----
// Self-checking bench for the serial audio transmit channel.
`timescale 1ns/1ps
`default_nettype none
module itf_channel_tb_top;
  import itf_pkg::*;
  localparam logic [15:0] CTL = ITF_WIN_CH0 + ITF_CTL_OFS;
  localparam logic [15:0] DIV = ITF_WIN_CH0 + ITF_DIV_OFS;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  itf_req_s cpu_req = '0;
  logic [31:0] cpu_rdata;
  logic win_full, bit_clock_out, frame_select_out, serial_data_out;
  logic adc_start, fifo_space_irq;
  int num_errors = 0;
  int n_compared = 0;
  int n_irq = 0;
  int n_adc = 0;
  always #25 ref_clk = ~ref_clk;
  itf_channel #(.CH(0), .DEPTH(32)) itf_channel_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .cpu_req(cpu_req),
    .cpu_rdata(cpu_rdata), .win_full(win_full), .pll_tick(1'b0),
    .bit_clock_out(bit_clock_out), .frame_select_out(frame_select_out),
    .serial_data_out(serial_data_out), .adc_start(adc_start),
    .fifo_space_irq(fifo_space_irq));
  itf_dac_model itf_dac_model_inst (.bit_clock_out(bit_clock_out),
    .frame_select_out(frame_select_out), .serial_data_out(serial_data_out));
  always @(negedge ref_clk) begin
    n_irq <= n_irq + int'(fifo_space_irq === 1'b1);
    n_adc <= n_adc + int'(adc_start === 1'b1);
  end
  function automatic logic [31:0] wd(input int k);
    return {16'ha000 + 16'(k), 16'h5000 + 16'(k)};
  endfunction
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic bus_wr(input logic [15:0] a, input logic [1:0] sz,
                        input logic [31:0] d);
    @(negedge ref_clk);
    cpu_req = '{1'b1, 1'b0, sz, a, d};
    @(negedge ref_clk);
    cpu_req.wr = 1'b0;
  endtask
  task automatic bus_rd(input logic [15:0] a, output logic [31:0] d);
    @(negedge ref_clk);
    cpu_req = '{1'b0, 1'b1, ITF_SZ_2, a, 32'h0};
    @(negedge ref_clk);
    cpu_req.rd = 1'b0;
    d = cpu_rdata;
  endtask
  task automatic t_reset();
    logic [31:0] v;
    chk("ck_idle", 32'h1, 32'(bit_clock_out));
    chk("ws_idle", 32'h0, 32'(frame_select_out));
    bus_rd(CTL, v);
    chk("ctl_reset", {16'h0, ITF_CTL_RST | 16'h0800}, v);
  endtask
  task automatic t_sizes();
    logic [31:0] v;
    bus_wr(ITF_WIN_CH0, ITF_SZ_1, 32'h1111_1111);
    bus_wr(ITF_WIN_CH0, ITF_SZ_2, 32'h2222_2222);
    bus_wr(ITF_WIN_CH1, ITF_SZ_4, 32'h3333_3333);
    bus_rd(CTL, v);
    chk("empty_small", 32'h1, 32'(v[ITF_B_EMPTY]));
    // two blocks, then one write refused while full
    for (int k = 0; k < 33; k++) begin
      bus_wr(ITF_WIN_CH0, ITF_SZ_4, (k < 32) ? wd(k) : 32'hffff_ffff);
    end
    bus_rd(CTL, v);
    chk("empty_fill", 32'h0, 32'(v[ITF_B_EMPTY]));
    chk("full", 32'h1, 32'(win_full));
  endtask
  task automatic drain(input int settle);
    logic [31:0] v;
    v = 32'h0;
    for (int t = 0; t < 80 && v[ITF_B_EMPTY] !== 1'b1; t++) begin
      repeat (64) @(negedge ref_clk);
      bus_rd(CTL, v);
    end
    chk("empty_end", 32'h1, 32'(v[ITF_B_EMPTY]));
    repeat (settle) @(negedge ref_clk);
  endtask
  task automatic t_stream();
    logic [31:0] e;
    int i0;
    int j;
    bus_wr(DIV, ITF_SZ_2, 32'h0000_2004);
    bus_wr(CTL, ITF_SZ_2, 32'h0000_004a);
    i0 = n_irq;
    bus_wr(CTL, ITF_SZ_2, 32'h0000_00ca);
    drain(300);
    chk("irq_count", 32'd2, 32'(n_irq - i0));
    j = 0;
    while (j < 200 && itf_dac_model_inst.got[j] == 16'h0) begin
      j++;
    end
    for (int k = 0; k < 65; k++) begin
      e = (k < 64) ? wd(k / 2) : 32'h0;
      e = (k % 2 == 1) ? {16'h0, e[31:16]} : {16'h0, e[15:0]};
      chk("sample", e, {16'h0, itf_dac_model_inst.got[j + k]});
    end
    bus_wr(CTL, ITF_SZ_2, 32'h0000_004a);
  endtask
  task automatic t_abort();
    logic [31:0] v;
    int n0;
    int a0;
    for (int k = 0; k < 16; k++) begin
      bus_wr(ITF_WIN_CH0, ITF_SZ_4, wd(k + 40));
    end
    bus_wr(CTL, ITF_SZ_2, 32'h0000_00ca);
    repeat (200) @(negedge ref_clk);
    bus_wr(CTL, ITF_SZ_2, 32'h0000_004a);
    bus_wr(CTL, ITF_SZ_2, 32'h0000_004b);
    a0 = n_adc;
    bus_rd(CTL, v);
    chk("empty_stop", 32'h1, 32'(v[ITF_B_EMPTY]));
    repeat (1280) @(negedge ref_clk);
    chk("adc_count", 32'h1, 32'((n_adc - a0) inside {[9:11]}));
    n0 = itf_dac_model_inst.got.size();
    bus_wr(CTL, ITF_SZ_2, 32'h0000_00cb);
    repeat (600) @(negedge ref_clk);
    for (int k = n0; k < itf_dac_model_inst.got.size(); k++) begin
      chk("stale", 32'h0, {16'h0, itf_dac_model_inst.got[k]});
    end
    bus_wr(CTL, ITF_SZ_2, 32'h0000_0000);
    repeat (20) @(negedge ref_clk);
    chk("ck_stop", 32'h1, 32'(bit_clock_out));
    chk("ws_stop", 32'h0, 32'(frame_select_out));
    bus_wr(CTL, ITF_SZ_2, 32'h0000_0200);
    repeat (4) @(negedge ref_clk);
    chk("ck_rise_idle", 32'h0, 32'(bit_clock_out));
  endtask
  task automatic t_mono();
    logic [31:0] e;
    int n0;
    int i0;
    int j;
    n0 = itf_dac_model_inst.got.size();
    i0 = n_irq;
    for (int k = 0; k < 16; k++) begin
      bus_wr(ITF_WIN_CH0, ITF_SZ_4, wd(k + 8));
    end
    bus_wr(CTL, ITF_SZ_2, 32'h0000_144a);
    bus_wr(CTL, ITF_SZ_2, 32'h0000_14ca);
    drain(600);
    chk("irq_mono", 32'h1, 32'(n_irq - i0));
    j = n0;
    while (j < n0 + 100 && itf_dac_model_inst.got[j] == 16'h0) begin
      j++;
    end
    for (int k = 0; k < 64; k++) begin
      e = wd(k / 4 + 8);
      e = (k % 4 == 0) ? {16'h0, e[31:16]} : {16'h0, e[15:0]};
      e = (k % 2 == 1) ? 32'h0 : e;
      chk("mono", e, {16'h0, itf_dac_model_inst.got[j + k]});
    end
    bus_wr(CTL, ITF_SZ_2, 32'h0000_144a);
  endtask
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    t_reset();
    t_sizes();
    t_stream();
    t_abort();
    t_mono();
    close_out();
  end
  initial begin
    #(50 * 30000);
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire

// ---- verif/itf_chk.sv ----
// Port-level assertions for the serial audio transmit channel.
`timescale 1ns/1ps
`default_nettype none
module itf_chk
  import itf_pkg::*;
#(
  parameter int CH = 0,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire itf_req_s cpu_req,
  input wire logic [31:0] cpu_rdata,
  input wire logic win_full,
  input wire logic pll_tick,
  input wire logic bit_clock_out,
  input wire logic frame_select_out,
  input wire logic serial_data_out,
  input wire logic adc_start,
  input wire logic fifo_space_irq
);
  localparam logic [15:0] BASE = (CH == 0) ? ITF_WIN_CH0 : ITF_WIN_CH1;
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  // Mirror of the low control byte
  always_comb begin
    ctl_nxt = ctl_r;
    if (cpu_req.wr && cpu_req.addr == BASE + ITF_CTL_OFS) begin
      ctl_nxt = cpu_req.wdata[7:0];
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= 8'h00;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_irq_pulse;
    fifo_space_irq |=> !fifo_space_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq width");
  property p_adc_cause;
    adc_start |-> CH == 0 && $rose(frame_select_out)
      && $past(ctl_r[0] && ctl_r[6]);
  endproperty
  a_adc_cause: assert property (p_adc_cause) else $error("adc cause");
  property p_adc_each;
    CH == 0 && $rose(frame_select_out) && ctl_r[0] && ctl_r[6]
      && $past(ctl_r[0] && ctl_r[6]) |-> adc_start;
  endproperty
  a_adc_each: assert property (p_adc_each) else $error("adc missed");
  property p_full_cause;
    $rose(win_full) |->
      $past(cpu_req.wr && cpu_req.size == ITF_SZ_4 && cpu_req.addr == BASE);
  endproperty
  a_full_cause: assert property (p_full_cause) else $error("full cause");
  property p_flush;
    $fell(ctl_r[ITF_B_TX_RUN]) |-> ##[0:2] !win_full;
  endproperty
  a_flush: assert property (p_flush) else $error("no flush");
  property p_ws_idle;
    !ctl_r[6] && !$past(ctl_r[6]) |-> !frame_select_out;
  endproperty
  a_ws_idle: assert property (p_ws_idle) else $error("ws idle");
  property p_ck_idle;
    !ctl_r[6] && !$past(ctl_r[6]) && !$past(ctl_r[6], 2)
      && !$past(cpu_req.wr) && !$past(cpu_req.wr, 2)
      |-> $stable(bit_clock_out);
  endproperty
  a_ck_idle: assert property (p_ck_idle) else $error("ck idle");
  property p_sd_idle;
    !ctl_r[7] && !$past(ctl_r[7]) |-> !serial_data_out;
  endproperty
  a_sd_idle: assert property (p_sd_idle) else $error("sd idle");
endmodule
bind itf_channel itf_chk #(.CH(CH), .DEPTH(DEPTH)) itf_chk_inst (
  .ref_clk(ref_clk), .rst_b(rst_b), .cpu_req(cpu_req),
  .cpu_rdata(cpu_rdata), .win_full(win_full), .pll_tick(pll_tick),
  .bit_clock_out(bit_clock_out), .frame_select_out(frame_select_out),
  .serial_data_out(serial_data_out), .adc_start(adc_start),
  .fifo_space_irq(fifo_space_irq));
`default_nettype wire

// ---- verif/itf_dac_model.sv ----
// Receiving converter model that rebuilds samples from the serial pins.
`timescale 1ns/1ps
`default_nettype none
module itf_dac_model (
  input wire logic bit_clock_out,
  input wire logic frame_select_out,
  input wire logic serial_data_out
);
  logic [15:0] shift_r = 16'h0000;
  logic ws_r = 1'b0;
  logic [15:0] got [$];
  always @(posedge bit_clock_out) begin
    if (frame_select_out !== ws_r) begin
      got.push_back(shift_r);
    end
    ws_r <= frame_select_out;
    shift_r <= {shift_r[14:0], serial_data_out};
  end
endmodule
`default_nettype wire
